// ---- verilog/eqf_coeff_bank.v ----
// AHB-Lite register bank for channel A equalization filter taps six to nine
//
// Overview of operation
// - Each 12-bit coefficient field is a signed two's-complement tap weight.
// - Offset 0x423 drives tap six of converter A filter in dual mode.
// - In single mode the same register is tap six of shared filter.
// - Offset 0x425 drives tap seven, converter A or shared filter.
// - Offset 0x427 drives tap eight, converter A or shared filter.
// - Offset 0x429 drives tap nine, the last, converter A or shared.
// - All four registers, reserved bits too, reset to zero.
// - Filter has nine taps; only centre tap is 18 bits, these 12.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`include "eqf_coeff_regs.vh"

module eqf_coeff_bank
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [2:0]  hburst,
  input  wire [3:0]  hprot,
  input  wire        hmastlock,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        single_mode,
  output wire [11:0] dual_a_tap6,
  output wire [11:0] dual_a_tap7,
  output wire [11:0] dual_a_tap8,
  output wire [11:0] dual_a_tap9,
  output wire [11:0] shared_tap6,
  output wire [11:0] shared_tap7,
  output wire [11:0] shared_tap8,
  output wire [11:0] shared_tap9
);

  wire [15:0] chan_a_tap6_weight;
  wire [15:0] chan_a_tap7_weight;
  wire [15:0] chan_a_tap8_weight;
  wire [15:0] chan_a_tap9_weight;
  wire        wr_en;
  wire [11:0] wr_idx;
  wire [15:0] wr_half;
  wire        rd_req;
  wire [11:0] req_idx;
  wire        mode_single;
  reg  [15:0] rd_word;
  reg  [31:0] hrdata_next;

  // Single-cycle slave: never stalls, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  eqf_ahb_front i_front
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .hwdata  (hwdata),
    .rd_req  (rd_req),
    .req_idx (req_idx),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_half)
  );

  always @*
  begin
    case (req_idx)
      `EQF_TAP6_IDX: rd_word = chan_a_tap6_weight;
      `EQF_TAP7_IDX: rd_word = chan_a_tap7_weight;
      `EQF_TAP8_IDX: rd_word = chan_a_tap8_weight;
      `EQF_TAP9_IDX: rd_word = chan_a_tap9_weight;
      default:       rd_word = 16'h0000;
    endcase
    hrdata_next = rd_req ? {16'h0000, rd_word} : 32'h00000000;
  end

  // Read data stands for the one data-phase cycle, zero otherwise
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else
      hrdata <= hrdata_next;
  end

  // Mode strap may come from another domain
  eqf_sync2 i_mode_sync
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (single_mode),
    .sync_out (mode_single)
  );

  eqf_tap_slot
  #(
    .TAP_IDX (`EQF_TAP6_IDX)
  )
  i_tap6
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .wr_en        (wr_en),
    .wr_idx       (wr_idx),
    .wr_data      (wr_half),
    .route_single (mode_single),
    .weight       (chan_a_tap6_weight),
    .dual_tap     (dual_a_tap6),
    .shared_tap   (shared_tap6)
  );

  eqf_tap_slot
  #(
    .TAP_IDX (`EQF_TAP7_IDX)
  )
  i_tap7
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .wr_en        (wr_en),
    .wr_idx       (wr_idx),
    .wr_data      (wr_half),
    .route_single (mode_single),
    .weight       (chan_a_tap7_weight),
    .dual_tap     (dual_a_tap7),
    .shared_tap   (shared_tap7)
  );

  eqf_tap_slot
  #(
    .TAP_IDX (`EQF_TAP8_IDX)
  )
  i_tap8
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .wr_en        (wr_en),
    .wr_idx       (wr_idx),
    .wr_data      (wr_half),
    .route_single (mode_single),
    .weight       (chan_a_tap8_weight),
    .dual_tap     (dual_a_tap8),
    .shared_tap   (shared_tap8)
  );

  eqf_tap_slot
  #(
    .TAP_IDX (`EQF_TAP9_IDX)
  )
  i_tap9
  (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .wr_en        (wr_en),
    .wr_idx       (wr_idx),
    .wr_data      (wr_half),
    .route_single (mode_single),
    .weight       (chan_a_tap9_weight),
    .dual_tap     (dual_a_tap9),
    .shared_tap   (shared_tap9)
  );

endmodule

// Bus front end: takes the address phase and holds it for the data phase
module eqf_ahb_front
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire        rd_req,
  output wire [11:0] req_idx,
  output reg         wr_en,
  output reg  [11:0] wr_idx,
  output wire [15:0] wr_data
);

  wire addr_phase;

  // NONSEQ and SEQ both start a transfer; BUSY and IDLE are ignored
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_req     = addr_phase & ~hwrite;
  // Byte address is four times the printed index; upper bits above index
  // width alias, which keeps the decoder small
  assign req_idx    = haddr[13:2];
  // Only the low half carries a register; the upper half is dropped
  assign wr_data    = hwdata[15:0];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_en  <= 1'b0;
      wr_idx <= 12'h000;
    end
    else
    begin
      wr_en  <= addr_phase & hwrite;
      wr_idx <= req_idx;
    end
  end

endmodule

// One tap weight with its write decode and its routing to either filter
module eqf_tap_slot
#(
  parameter [11:0] TAP_IDX = `EQF_TAP6_IDX,
  parameter        REG_W   = `EQF_REG_W,
  parameter        COEF_W  = `EQF_COEF_MSB - `EQF_COEF_LSB + 1
)
(
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              wr_en,
  input  wire [11:0]       wr_idx,
  input  wire [REG_W-1:0]  wr_data,
  input  wire              route_single,
  output wire [REG_W-1:0]  weight,
  output reg  [COEF_W-1:0] dual_tap,
  output reg  [COEF_W-1:0] shared_tap
);

  reg  [REG_W-1:0]  weight_reg;
  reg  [REG_W-1:0]  weight_next;
  wire              hit;
  wire [COEF_W-1:0] coef;

  assign hit    = wr_en & (wr_idx == TAP_IDX);
  assign weight = weight_reg;
  // Reserved bits stay out of the datapath; consumer takes coef as signed,
  // and the 18-bit centre tap lives in another bank
  assign coef   = weight_reg[`EQF_COEF_MSB:`EQF_COEF_LSB];

  always @*
  begin
    if (hit)
      weight_next = wr_data;
    else
      weight_next = weight_reg;
  end

  // Whole word kept so reserved bits read back as written
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      weight_reg <= `EQF_REG_RESET;
    else
      weight_reg <= weight_next;
  end

  // Idle filter sees zero so a mode switch never mixes weights
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dual_tap   <= {COEF_W{1'b0}};
      shared_tap <= {COEF_W{1'b0}};
    end
    else if (route_single)
    begin
      dual_tap   <= {COEF_W{1'b0}};
      shared_tap <= coef;
    end
    else
    begin
      dual_tap   <= coef;
      shared_tap <= {COEF_W{1'b0}};
    end
  end

endmodule

// Two-flop synchroniser for a level from outside the clock domain
module eqf_sync2
(
  input  wire hclk,
  input  wire hresetn,
  input  wire async_in,
  output wire sync_out
);

  reg [1:0] sync_reg;

  // Only the second stage is read, the first may be metastable
  assign sync_out = sync_reg[1];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sync_reg <= 2'b00;
    else
      sync_reg <= {sync_reg[0], async_in};
  end

endmodule

// ---- verilog/eqf_coeff_regs.vh ----
// Register map and constants for the channel A tap six to nine weight bank
`ifndef EQF_COEFF_REGS_VH
`define EQF_COEFF_REGS_VH
// Printed offsets are register indexes; byte address is four times index
`define EQF_TAP6_IDX      12'h423
`define EQF_TAP7_IDX      12'h425
`define EQF_TAP8_IDX      12'h427
`define EQF_TAP9_IDX      12'h429
`define EQF_REG_W         16
`define EQF_COEF_MSB      11
`define EQF_COEF_LSB      0
`define EQF_RSVD_MSB      15
`define EQF_RSVD_LSB      12
`define EQF_REG_RESET     16'h0000
`define EQF_FILTER_TAPS   9
`define EQF_CENTER_BITS   18
`define EQF_HTRANS_NONSEQ 2'h2
`define EQF_HTRANS_SEQ    2'h3
`define EQF_HSIZE_WORD    3'h2
`endif

// ---- testbench/eqf_bank_chk_asserts.sv ----
// Assertion checker for the tap weight bank
`timescale 1ns/10ps
module eqf_bank_chk (
  input wire        hclk, hresetn, hsel, hwrite, hready, single_mode,
  input wire [31:0] haddr, hwdata, hrdata,
  input wire [1:0]  htrans,
  input wire [11:0] dual_a_tap6, dual_a_tap7, dual_a_tap8, dual_a_tap9,
  input wire [11:0] shared_tap6, shared_tap7, shared_tap8, shared_tap9
);
  reg        wr_q;
  reg [11:0] wr_idx;
  reg [3:0]  ms;
  // Mode held for four edges, so the sync stages have settled
  wire st = ms == {4{single_mode}};
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {wr_q, wr_idx, ms} <= 17'h0;
    else
      {wr_q, wr_idx, ms} <= {hsel & hready & htrans[1] & hwrite,
                             haddr[13:2], ms[2:0], single_mode};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rst_clear_a: assert property ($rose(hresetn) |-> hrdata == 0
    && (dual_a_tap6 | dual_a_tap7 | dual_a_tap8 | dual_a_tap9 | shared_tap6
    | shared_tap7 | shared_tap8 | shared_tap9) == 0) else $error("not clear");
  dual_idle_a: assert property (single_mode[*4] |-> (dual_a_tap6
    | dual_a_tap7 | dual_a_tap8 | dual_a_tap9) == 0) else $error("dual on");
  shared_idle_a: assert property (!single_mode[*4] |-> (shared_tap6
    | shared_tap7 | shared_tap8 | shared_tap9) == 0) else $error("shr on");
  tap6_load_a: assert property (wr_q && wr_idx == 12'h423 && st |-> ##2
    (single_mode ? shared_tap6 : dual_a_tap6) == $past(hwdata[11:0], 2))
    else $error("tap6 bad");
  tap7_load_a: assert property (wr_q && wr_idx == 12'h425 && st |-> ##2
    (single_mode ? shared_tap7 : dual_a_tap7) == $past(hwdata[11:0], 2))
    else $error("tap7 bad");
  tap8_load_a: assert property (wr_q && wr_idx == 12'h427 && st |-> ##2
    (single_mode ? shared_tap8 : dual_a_tap8) == $past(hwdata[11:0], 2))
    else $error("tap8 bad");
  tap9_load_a: assert property (wr_q && wr_idx == 12'h429 && st |-> ##2
    (single_mode ? shared_tap9 : dual_a_tap9) == $past(hwdata[11:0], 2))
    else $error("tap9 bad");
  upper_zero_a: assert property (hrdata[31:16] == 0) else $error("hi");
endmodule
bind eqf_coeff_bank eqf_bank_chk i_chk (.*);

// ---- testbench/testbench.sv ----
// Self-checking bench for the tap weight bank
`timescale 1ns/10ps
module testbench;
  reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, single_mode = 0;
  reg  [31:0] haddr = 0, hwdata = 0, q;
  reg  [1:0]  htrans = 0;
  wire [31:0] hrdata;
  wire        rdy, resp;
  wire [47:0] dv, sv;
  integer     err_total = 0, total_checks = 0, i;
  reg  [11:0] idx [0:3] = '{12'h423, 12'h425, 12'h427, 12'h429};
  reg  [15:0] val [0:3] = '{16'hf801, 16'h7ff2, 16'ha800, 16'h0123};
  always #12.5 hclk = ~hclk;
  eqf_coeff_bank i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hburst(3'h0), .hprot(4'h0), .hmastlock(1'b0), .hready(rdy),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy), .hresp(resp),
    .single_mode(single_mode), .dual_a_tap6(dv[11:0]),
    .dual_a_tap7(dv[23:12]), .dual_a_tap8(dv[35:24]),
    .dual_a_tap9(dv[47:36]), .shared_tap6(sv[11:0]),
    .shared_tap7(sv[23:12]), .shared_tap8(sv[35:24]),
    .shared_tap9(sv[47:36]));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 18'h0, a, 2'h0, 2'h2, w};
    do @(posedge hclk); while (rdy !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (rdy !== 1'b1);
    q = hrdata;
    chk("okay response", resp, 0);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Whole run is under a hundred transfers
  initial
  begin
    #50000;
    err_total++;
    summarize;
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    for (i = 0; i < 4; i++)
    begin
      xfer(0, idx[i], 0);
      chk("reset value", q, 0);
      xfer(1, idx[i], {16'hdead, val[i]});
    end
    xfer(1, 12'h424, 32'hffff);
    xfer(0, 12'h424, 0);
    chk("unmapped", q, 0);
    $display("test reset and unmapped done");
    for (i = 0; i < 4; i++)
    begin
      xfer(0, idx[i], 0);
      chk("readback", q, val[i]);
      chk("dual tap", dv[i*12 +: 12], val[i][11:0]);
      chk("shared idle", sv[i*12 +: 12], 0);
    end
    chk("sign", $signed(dv[35:24]) < 0, 1);
    $display("test dual mode done");
    single_mode <= 1;
    repeat (5) @(posedge hclk);
    for (i = 0; i < 4; i++)
    begin
      chk("shared tap", sv[i*12 +: 12], val[i][11:0]);
      chk("dual idle", dv[i*12 +: 12], 0);
      xfer(1, idx[i], 32'h5a0 + i);
      xfer(0, idx[i], 0);
      chk("readback new", q, 32'h5a0 + i);
      chk("shared new", sv[i*12 +: 12], 12'h5a0 + i);
    end
    $display("test single mode done");
    hresetn <= 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    for (i = 0; i < 4; i++)
    begin
      xfer(0, idx[i], 0);
      chk("reset again", q, 0);
    end
    chk("reset taps", |{dv, sv}, 0);
    $display("test mid-run reset done");
    summarize;
  end
endmodule
